/* File: hdl/sirr_top.sv */
// command engine for selective idle, random and read, with its apb register file
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module sirr_top #(
    parameter int unsigned CFG_WORDS  = 22,
    parameter int unsigned OTP_WORDS  = 16,
    parameter int unsigned DATA_WORDS = 128
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_nonce_req,
    output logic      [31:0] o_seed,
    output logic             o_idle,
    output logic             o_busy
);
    // ***************************************************
    // register file
    // ***************************************************
    logic [7:0]  op_reg,    op_next;
    logic [7:0]  p1_reg,    p1_next;
    logic [15:0] p2_reg,    p2_next;
    logic [7:0]  dlen_reg,  dlen_next;
    logic [3:0]  cfg_reg,   cfg_next;
    logic [7:0]  sel_reg,   sel_next;
    logic [15:0] sec_reg,   sec_next;
    logic [15:0] enc_reg,   enc_next;
    logic [7:0]  maddr_reg, maddr_next;
    logic [31:0] key_reg    [8];
    logic [31:0] key_next   [8];
    logic [31:0] prdata_reg, prdata_next;

    logic [31:0] resp_reg   [8];
    logic [31:0] resp_next  [8];
    sirr_pkg::sirr_state_t state_reg, state_next;
    logic [2:0]  cnt_reg,   cnt_next;
    logic [5:0]  len_reg,   len_next;
    logic [7:0]  code_reg,  code_next;
    logic        idle_reg,  idle_next;
    logic        done_reg,  done_next;
    logic [31:0] seed_reg,  seed_next;

    logic        wr;
    logic        go;
    logic        wake;
    logic        mem_we;
    logic        busy;
    logic [31:0] rng_word;
    logic [31:0] mem_rdata;
    logic [7:0]  mem_raddr;

    wire logic cfg_lock  = cfg_reg[0];
    wire logic otp_lock  = cfg_reg[1];
    wire logic data_lock = cfg_reg[2];
    wire logic legacy    = cfg_reg[3];

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a < sirr_pkg::A_END) && (a != sirr_pkg::A_HOLE);
    endfunction

    function automatic logic [31:0] rd_mux(input logic [11:0] a);
        rd_mux = 32'h00000000;
        if (a == sirr_pkg::A_CMD) begin
            rd_mux = {p2_reg, p1_reg, op_reg};
        end else if (a == sirr_pkg::A_CTRL) begin
            rd_mux = {16'h0000, dlen_reg, 8'h00};
        end else if (a == sirr_pkg::A_STATUS) begin
            rd_mux = {8'h00, code_reg, 2'b00, len_reg, 5'h00, done_reg, idle_reg, busy};
        end else if (a == sirr_pkg::A_CFG) begin
            rd_mux = {16'h0000, sel_reg, 4'h0, cfg_reg};
        end else if (a == sirr_pkg::A_SLOT) begin
            rd_mux = {enc_reg, sec_reg};
        end else if (a == sirr_pkg::A_MADDR) begin
            rd_mux = {24'h000000, maddr_reg};
        end else if (a[11:5] == sirr_pkg::A_RESP_PAGE) begin
            rd_mux = resp_reg[a[4:2]];
        end
    endfunction

    assign busy   = (state_reg != sirr_pkg::ST_IDLE);
    assign wr     = i_ce && i_psel && i_penable && i_pwrite && addr_ok(i_paddr);
    assign go     = wr && (i_paddr == sirr_pkg::A_CTRL) && i_pwdata[sirr_pkg::CTRL_GO];
    assign wake   = wr && (i_paddr == sirr_pkg::A_CTRL) && i_pwdata[sirr_pkg::CTRL_WAKE];
    assign mem_we = wr && (i_paddr == sirr_pkg::A_MDATA);

    always_comb begin
        op_next     = op_reg;
        p1_next     = p1_reg;
        p2_next     = p2_reg;
        dlen_next   = dlen_reg;
        cfg_next    = cfg_reg;
        sel_next    = sel_reg;
        sec_next    = sec_reg;
        enc_next    = enc_reg;
        maddr_next  = maddr_reg;
        key_next    = key_reg;
        prdata_next = prdata_reg;
        // read data is latched in the setup cycle so it comes from a flop
        if (i_psel && !i_penable && !i_pwrite) begin
            prdata_next = rd_mux(i_paddr);
        end
        if (wr) begin
            // a command in flight keeps its fields steady
            if (i_paddr == sirr_pkg::A_CMD && !busy) begin
                op_next = i_pwdata[7:0];
                p1_next = i_pwdata[15:8];
                p2_next = i_pwdata[31:16];
            end
            if (i_paddr == sirr_pkg::A_CTRL && !busy) begin
                dlen_next = i_pwdata[15:8];
            end
            if (i_paddr == sirr_pkg::A_CFG) begin
                cfg_next = i_pwdata[3:0];
                sel_next = i_pwdata[15:8];
            end
            if (i_paddr == sirr_pkg::A_SLOT) begin
                sec_next = i_pwdata[15:0];
                enc_next = i_pwdata[31:16];
            end
            if (i_paddr == sirr_pkg::A_MADDR) begin
                maddr_next = i_pwdata[7:0];
            end
            if (mem_we) begin
                maddr_next = maddr_reg + 8'h01;
            end
            if (i_paddr[11:5] == sirr_pkg::A_KEY_PAGE) begin
                key_next[i_paddr[4:2]] = i_pwdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            op_reg     <= 8'h00;
            p1_reg     <= 8'h00;
            p2_reg     <= 16'h0000;
            dlen_reg   <= 8'h00;
            cfg_reg    <= 4'h0;
            sel_reg    <= 8'h00;
            sec_reg    <= 16'h0000;
            enc_reg    <= 16'h0000;
            maddr_reg  <= 8'h00;
            prdata_reg <= 32'h00000000;
            for (int i = 0; i < 8; i++) begin
                key_reg[i] <= 32'h00000000;
            end
        end else if (i_ce) begin
            op_reg     <= op_next;
            p1_reg     <= p1_next;
            p2_reg     <= p2_next;
            dlen_reg   <= dlen_next;
            cfg_reg    <= cfg_next;
            sel_reg    <= sel_next;
            sec_reg    <= sec_next;
            enc_reg    <= enc_next;
            maddr_reg  <= maddr_next;
            prdata_reg <= prdata_next;
            key_reg    <= key_next;
        end
    end

    assign o_prdata  = prdata_reg;
    assign o_pready  = i_ce;
    assign o_pslverr = i_psel && i_penable && !addr_ok(i_paddr);

    // ***************************************************
    // command decode and checks
    // ***************************************************
    wire logic        big   = p1_reg[7];
    wire logic [1:0]  zone  = p1_reg[1:0];
    // block reads ignore the low three address bits
    // block alignment
    wire logic [15:0] start = big ? {p2_reg[15:3], 3'b000} : p2_reg;
    wire logic [3:0]  slot  = start[6:3];
    wire logic [2:0]  last  = (big || op_reg == sirr_pkg::OP_RANDOM) ? 3'h7 : 3'h0;

    function automatic logic [16:0] zone_words(input logic [1:0] z);
        zone_words = 17'(CFG_WORDS);
        if (z == sirr_pkg::ZONE_OTP) begin
            zone_words = 17'(OTP_WORDS);
        end else if (z == sirr_pkg::ZONE_DATA) begin
            zone_words = 17'(DATA_WORDS);
        end
    endfunction

    function automatic logic [7:0] zone_base(input logic [1:0] z);
        zone_base = sirr_pkg::BASE_CFG;
        if (z == sirr_pkg::ZONE_OTP) begin
            zone_base = sirr_pkg::BASE_OTP;
        end else if (z == sirr_pkg::ZONE_DATA) begin
            zone_base = sirr_pkg::BASE_DATA;
        end
    endfunction

    logic perr;
    logic xerr;
    logic enc_on;
    logic sel_match;

    always_comb begin
        perr = (dlen_reg != 8'h00);
        unique case (op_reg)
            sirr_pkg::OP_IDLE_SEL: perr = perr || (p2_reg != 16'h0000);
            sirr_pkg::OP_RANDOM:   perr = perr || (p2_reg != 16'h0000) || (p1_reg[7:1] != 7'h00);
            sirr_pkg::OP_READ:     perr = perr || (p1_reg[6:2] != 5'h00) || (zone == 2'h3);
            default:               perr = 1'b1;
        endcase
        xerr = ({1'b0, start} + (big ? 17'h00008 : 17'h00001)) > zone_words(zone);
        if (zone == sirr_pkg::ZONE_DATA) begin
            xerr = xerr || !data_lock || (sec_reg[slot] && !big) || (sec_reg[slot] && !enc_reg[slot]);
        end else if (zone == sirr_pkg::ZONE_OTP) begin
            xerr = xerr || !otp_lock || (legacy && (big || start[15:1] == 15'h0000));
        end
        // only data slots can be encrypted
        enc_on    = (zone == sirr_pkg::ZONE_DATA) && enc_reg[slot];
        sel_match = (p1_reg == sel_reg);
    end

    wire logic [2:0]  kidx     = big ? cnt_reg : p2_reg[2:0];
    wire logic [31:0] key_word = key_reg[kidx];
    wire logic [31:0] rnd_word = cfg_lock ? (rng_word ^ seed_reg) : sirr_pkg::TEST_WORD;

    assign mem_raddr = zone_base(zone) + start[7:0] + {5'b00000, cnt_reg};

    // ***************************************************
    // execution engine
    // ***************************************************
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        len_next   = len_reg;
        code_next  = code_reg;
        idle_next  = idle_reg;
        done_next  = done_reg;
        seed_next  = seed_reg;
        resp_next  = resp_reg;
        if (wake) begin
            idle_next = 1'b0;
        end
        // nonce engine draws on the same seed
        if (i_nonce_req && state_reg == sirr_pkg::ST_IDLE) begin
            seed_next = seed_reg ^ rng_word;
        end
        unique case (state_reg)
            sirr_pkg::ST_IDLE: begin
                // a dozing device ignores commands until woken
                if (go && !idle_reg) begin
                    state_next = sirr_pkg::ST_CHECK;
                    done_next  = 1'b0;
                    cnt_next   = 3'h0;
                end
            end
            sirr_pkg::ST_CHECK: begin
                state_next = sirr_pkg::ST_DONE;
                len_next   = sirr_pkg::LEN_BYTE;
                if (perr) begin
                    code_next    = sirr_pkg::RC_PARSE;
                    resp_next[0] = {24'h000000, sirr_pkg::RC_PARSE};
                end else if (op_reg == sirr_pkg::OP_IDLE_SEL) begin
                    if (sel_match) begin
                        code_next    = sirr_pkg::RC_OK;
                        resp_next[0] = {24'h000000, sirr_pkg::RC_OK};
                    end else begin
                        idle_next  = 1'b1;
                        state_next = sirr_pkg::ST_IDLE;
                    end
                end else if (op_reg == sirr_pkg::OP_RANDOM) begin
                    code_next  = sirr_pkg::RC_OK;
                    len_next   = sirr_pkg::LEN_BLOCK;
                    state_next = sirr_pkg::ST_FETCH;
                    // seed refreshed unless mode bit set
                    if (!p1_reg[0]) begin
                        seed_next = seed_reg ^ rng_word;
                    end
                end else if (xerr) begin
                    code_next    = sirr_pkg::RC_EXEC;
                    resp_next[0] = {24'h000000, sirr_pkg::RC_EXEC};
                end else begin
                    code_next  = sirr_pkg::RC_OK;
                    len_next   = big ? sirr_pkg::LEN_BLOCK : sirr_pkg::LEN_WORD;
                    state_next = sirr_pkg::ST_FETCH;
                end
            end
            sirr_pkg::ST_FETCH: begin
                if (op_reg == sirr_pkg::OP_RANDOM) begin
                    resp_next[cnt_reg] = rnd_word;
                    cnt_next           = cnt_reg + 3'h1;
                    if (cnt_reg == last) begin
                        state_next = sirr_pkg::ST_DONE;
                    end
                end else begin
                    state_next = sirr_pkg::ST_WAIT;
                end
            end
            sirr_pkg::ST_WAIT: begin
                // xor with scratch key when encrypted
                resp_next[cnt_reg] = mem_rdata ^ (enc_on ? key_word : 32'h00000000);
                cnt_next           = cnt_reg + 3'h1;
                state_next         = (cnt_reg == last) ? sirr_pkg::ST_DONE : sirr_pkg::ST_FETCH;
            end
            sirr_pkg::ST_DONE: begin
                done_next  = 1'b1;
                state_next = sirr_pkg::ST_IDLE;
            end
            default: state_next = sirr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg <= sirr_pkg::ST_IDLE;
            cnt_reg   <= 3'h0;
            len_reg   <= 6'h00;
            code_reg  <= 8'h00;
            idle_reg  <= 1'b0;
            done_reg  <= 1'b0;
            seed_reg  <= sirr_pkg::SEED_RST;
            for (int i = 0; i < 8; i++) begin
                resp_reg[i] <= 32'h00000000;
            end
        end else if (i_ce) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            len_reg   <= len_next;
            code_reg  <= code_next;
            idle_reg  <= idle_next;
            done_reg  <= done_next;
            seed_reg  <= seed_next;
            resp_reg  <= resp_next;
        end
    end

    assign o_seed = seed_reg;
    assign o_idle = idle_reg;
    assign o_busy = busy;

    sirr_mem #(
        .AW (sirr_pkg::MEM_AW),
        .DW (32)
    ) u_mem (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_we    (mem_we),
        .i_waddr (maddr_reg),
        .i_wdata (i_pwdata),
        .i_raddr (mem_raddr),
        .o_rdata (mem_rdata)
    );

    sirr_lfsr #(
        .W (32)
    ) u_rng (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .o_word  (rng_word)
    );

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_ce);

    wire logic chk = (state_reg == sirr_pkg::ST_CHECK) && !perr;

    sequence s_answer(logic [7:0] c);
        ##2 (done_reg && code_reg == c);
    endsequence

    a_sel_mismatch_idle: assert property (chk && op_reg == sirr_pkg::OP_IDLE_SEL && !sel_match
        |=> (idle_reg && state_reg == sirr_pkg::ST_IDLE) ##1 !done_reg)
        else $error("selector mismatch did not doze silently");
    a_sel_match_ok: assert property (chk && op_reg == sirr_pkg::OP_IDLE_SEL && sel_match
        |-> s_answer(sirr_pkg::RC_OK) and ##2 (!idle_reg && len_reg == sirr_pkg::LEN_BYTE))
        else $error("selector match did not answer zero");
    a_idle_cause_only: assert property ($rose(idle_reg)
        |-> $past(state_reg == sirr_pkg::ST_CHECK && op_reg == sirr_pkg::OP_IDLE_SEL))
        else $error("idle entered without idle command");
    a_random_block: assert property (chk && op_reg == sirr_pkg::OP_RANDOM
        |-> ##10 (done_reg && len_reg == sirr_pkg::LEN_BLOCK))
        else $error("random answer not thirty-two bytes on time");
    a_seed_kept: assert property (chk && op_reg == sirr_pkg::OP_RANDOM && p1_reg[0]
        |=> seed_reg == $past(seed_reg))
        else $error("seed changed with update suppressed");
    a_test_pattern: assert property (state_reg == sirr_pkg::ST_FETCH && op_reg == sirr_pkg::OP_RANDOM && !cfg_lock
        |=> resp_reg[$past(cnt_reg)] == sirr_pkg::TEST_WORD)
        else $error("test pattern missing before lock");
    a_range_error: assert property (chk && op_reg == sirr_pkg::OP_READ && xerr
        |-> s_answer(sirr_pkg::RC_EXEC))
        else $error("refused read not answered with error");
    a_encrypt_xor: assert property (state_reg == sirr_pkg::ST_WAIT && enc_on
        |=> resp_reg[$past(cnt_reg)] == ($past(mem_rdata) ^ $past(key_word)))
        else $error("encrypted word not xored with key");
    a_parse_error: assert property (state_reg == sirr_pkg::ST_CHECK && perr
        |-> s_answer(sirr_pkg::RC_PARSE))
        else $error("malformed command not answered with parse error");
endmodule
`default_nettype wire

/* File: hdl/sirr_pkg.sv */
// package: constants, register map and states of the selective idle / random / read command block
package sirr_pkg;

    localparam logic [7:0]  OP_IDLE_SEL = 8'h01;
    localparam logic [7:0]  OP_READ     = 8'h02;
    localparam logic [7:0]  OP_RANDOM   = 8'h1b;

    localparam logic [1:0]  ZONE_CFG    = 2'h0;
    localparam logic [1:0]  ZONE_OTP    = 2'h1;
    localparam logic [1:0]  ZONE_DATA   = 2'h2;

    localparam int unsigned MEM_AW      = 8;
    localparam logic [7:0]  BASE_CFG    = 8'h00;
    localparam logic [7:0]  BASE_OTP    = 8'h20;
    localparam logic [7:0]  BASE_DATA   = 8'h40;

    localparam logic [7:0]  RC_OK       = 8'h00;
    localparam logic [7:0]  RC_PARSE    = 8'h03;
    localparam logic [7:0]  RC_EXEC     = 8'h0f;

    localparam logic [5:0]  LEN_BYTE    = 6'h01;
    localparam logic [5:0]  LEN_WORD    = 6'h04;
    localparam logic [5:0]  LEN_BLOCK   = 6'h20;

    localparam logic [31:0] TEST_WORD   = 32'hffff0000;
    localparam logic [31:0] SEED_RST    = 32'h00000001;
    localparam logic [31:0] LFSR_TAPS   = 32'h80200003;
    localparam logic [31:0] LFSR_RST    = 32'h0000ace1;

    localparam logic [11:0] A_CMD       = 12'h000;
    localparam logic [11:0] A_CTRL      = 12'h004;
    localparam logic [11:0] A_STATUS    = 12'h008;
    localparam logic [11:0] A_CFG       = 12'h00c;
    localparam logic [11:0] A_SLOT      = 12'h010;
    localparam logic [11:0] A_MADDR     = 12'h014;
    localparam logic [11:0] A_MDATA     = 12'h018;
    localparam logic [11:0] A_HOLE      = 12'h01c;
    localparam logic [11:0] A_END       = 12'h060;
    localparam logic [6:0]  A_KEY_PAGE  = 7'h01;
    localparam logic [6:0]  A_RESP_PAGE = 7'h02;

    localparam int unsigned CTRL_GO     = 0;
    localparam int unsigned CTRL_WAKE   = 1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_FETCH = 3'b011,
        ST_WAIT  = 3'b010,
        ST_DONE  = 3'b110
    } sirr_state_t;

endpackage

/* File: hdl/sirr_mem.sv */
// nonvolatile zone store: one write port, one registered read port
`timescale 1ns/1ns
`default_nettype none
module sirr_mem #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 32
) (
    input  wire logic          i_clk,
    input  wire logic          i_ce,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_reg [2**AW];

    // no reset on the array: contents are loaded by software
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem_reg[i_waddr] <= i_wdata;
            end
            o_rdata <= mem_reg[i_raddr];
        end
    end
endmodule
`default_nettype wire

/* File: hdl/sirr_lfsr.sv */
// free-running generator standing in for the hardware entropy source
`timescale 1ns/1ns
`default_nettype none
module sirr_lfsr #(
    parameter int unsigned   W    = 32,
    parameter logic [W-1:0]  TAPS = sirr_pkg::LFSR_TAPS,
    parameter logic [W-1:0]  INIT = sirr_pkg::LFSR_RST
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    output logic      [W-1:0] o_word
);
    logic [W-1:0] state_reg;
    logic [W-1:0] state_next;

    always_comb begin
        state_next = {1'b0, state_reg[W-1:1]};
        if (state_reg[0]) begin
            state_next = state_next ^ TAPS;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg <= INIT;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    assign o_word = state_reg;
endmodule
`default_nettype wire

/* File: verif/sirr_nonce_model.sv */
// nonce engine stand-in driving the shared seed mix request
`timescale 1ns/1ns
`default_nettype none
module sirr_nonce_model (
    input  wire logic i_clk,
    input  wire logic i_fire,
    output logic      o_req
);
    initial o_req = 1'b0;
    // shared seed mix
    // one-cycle pulse; fired only while the command engine is idle
    always @(posedge i_clk) begin
        o_req <= i_fire;
    end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// testbench: apb command sequences with expected results
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk, rst_n, psel, penable, pwrite, fire, req;
    logic        pready, pslverr, idle, busy, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, r, s;
    int          errors, compares;
    sirr_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_nonce_req(req), .o_seed(seed), .o_idle(idle), .o_busy(busy));
    sirr_nonce_model nonce (.i_clk(clk), .i_fire(fire), .o_req(req));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task stop_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", {31'h0, pready}, 32'h1);
        if (pready !== 1'b1)
            stop_test;
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // start a command with no data bytes and poll for done
    task cmd(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2,
             input logic [7:0] code, input logic [5:0] len);
        int n;
        apb(1, sirr_pkg::A_CMD, {p2, p1, op});
        apb(1, sirr_pkg::A_CTRL, 32'h1);
        n = 0;
        do begin
            apb(0, sirr_pkg::A_STATUS, 0);
            n++;
        end while (r[2] !== 1'b1 && n < 40);
        chk("status", r, {8'h0, code, 2'h0, len, 8'h04});
        if (r[2] !== 1'b1)
            stop_test;
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, fire, paddr, pwdata} = '0;
        errors = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1;
        chk("seed", seed, 32'h1);
        chk("reset state", {30'h0, idle, busy}, 32'h0);
        apb(0, 12'h01c, 0);
        chk("unmapped", {r[31:1], err}, 32'h1);
        cmd(sirr_pkg::OP_RANDOM, 8'h01, 16'h0, 8'h00, 6'h20);
        for (int i = 0; i < 8; i++) begin
            apb(0, 12'(32'h40 + 4 * i), 0);
            chk("pattern", r, 32'hffff0000);
        end
        chk("seed kept", seed, 32'h1);
        fire <= 1;
        @(posedge clk);
        fire <= 0;
        repeat (4) @(posedge clk);
        chk("nonce mix", {31'h0, seed !== 32'h1}, 32'h1);
        s = seed;
        cmd(sirr_pkg::OP_RANDOM, 8'h00, 16'h0, 8'h00, 6'h20);
        chk("seed new", {31'h0, seed !== s}, 32'h1);
        cmd(sirr_pkg::OP_RANDOM, 8'h00, 16'h1, 8'h03, 6'h01);
        cmd(sirr_pkg::OP_RANDOM, 8'h02, 16'h0, 8'h03, 6'h01);
        cmd(8'h7f, 8'h00, 16'h0, 8'h03, 6'h01);
        // data bytes announced where none belong
        apb(1, sirr_pkg::A_CMD, {16'h0, 8'h01, sirr_pkg::OP_RANDOM});
        apb(1, sirr_pkg::A_CTRL, 32'h0401);
        repeat (6) @(posedge clk);
        apb(0, sirr_pkg::A_STATUS, 0);
        chk("data length", r, 32'h00030104);
        apb(1, sirr_pkg::A_MDATA, 32'h12345678);
        apb(1, sirr_pkg::A_MADDR, 32'h40);
        // scratch key loaded before encrypted read
        for (int i = 0; i < 8; i++) begin
            apb(1, sirr_pkg::A_MDATA, 32'h11110000 + 32'(i));
            apb(1, 12'(32'h20 + 4 * i), 32'ha5a50000 + 32'(i));
        end
        cmd(sirr_pkg::OP_READ, 8'h00, 16'h0, 8'h00, 6'h04);
        apb(0, 12'h040, 0);
        chk("config word", r, 32'h12345678);
        cmd(sirr_pkg::OP_READ, 8'h00, 16'd22, 8'h0f, 6'h01);
        cmd(sirr_pkg::OP_READ, 8'h03, 16'h0, 8'h03, 6'h01);
        cmd(sirr_pkg::OP_READ, 8'h04, 16'h0, 8'h03, 6'h01);
        cmd(sirr_pkg::OP_READ, 8'h01, 16'h0, 8'h0f, 6'h01);
        cmd(sirr_pkg::OP_READ, 8'h82, 16'h0, 8'h0f, 6'h01);
        // slot 0 secret and encrypted, slot 1 secret only
        apb(1, sirr_pkg::A_SLOT, 32'h00010003);
        apb(1, sirr_pkg::A_CFG, 32'h00005a04);
        cmd(sirr_pkg::OP_READ, 8'h82, 16'h5, 8'h00, 6'h20);
        for (int i = 0; i < 8; i++) begin
            apb(0, 12'(32'h40 + 4 * i), 0);
            chk("cipher", r, 32'hb4b40000);
        end
        cmd(sirr_pkg::OP_READ, 8'h00, 16'h0, 8'h00, 6'h04);
        apb(0, 12'h040, 0);
        chk("config plain", r, 32'h12345678);
        cmd(sirr_pkg::OP_READ, 8'h02, 16'h0, 8'h0f, 6'h01);
        cmd(sirr_pkg::OP_READ, 8'h82, 16'h8, 8'h0f, 6'h01);
        apb(1, sirr_pkg::A_CFG, 32'h00005a06);
        cmd(sirr_pkg::OP_READ, 8'h81, 16'h0, 8'h00, 6'h20);
        apb(1, sirr_pkg::A_CFG, 32'h00005a0e);
        cmd(sirr_pkg::OP_READ, 8'h81, 16'h2, 8'h0f, 6'h01);
        cmd(sirr_pkg::OP_READ, 8'h01, 16'h1, 8'h0f, 6'h01);
        cmd(sirr_pkg::OP_READ, 8'h01, 16'h2, 8'h00, 6'h04);
        apb(1, sirr_pkg::A_CFG, 32'h00005a0f);
        cmd(sirr_pkg::OP_RANDOM, 8'h01, 16'h0, 8'h00, 6'h20);
        apb(0, 12'h040, 0);
        chk("locked random", {31'h0, r !== 32'hffff0000}, 32'h1);
        cmd(sirr_pkg::OP_IDLE_SEL, 8'h5a, 16'h0, 8'h00, 6'h01);
        apb(1, sirr_pkg::A_CMD, {16'h0, 8'h33, sirr_pkg::OP_IDLE_SEL});
        apb(1, sirr_pkg::A_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        chk("dozing", {30'h0, idle, busy}, 32'h2);
        apb(0, sirr_pkg::A_STATUS, 0);
        chk("no answer", {29'h0, r[2:0]}, 32'h2);
        apb(1, sirr_pkg::A_CTRL, 32'h2);
        @(posedge clk);
        chk("awake", {31'h0, idle}, 32'h0);
        stop_test;
    end
endmodule
`default_nettype wire
